// ### rtl/otq_consts.svh
// Offsets, field positions, reset words and timing counts for the output 1 trigger.
// Assumes a 25 MHz system clock and word-aligned Avalon-MM byte addresses.
`ifndef OTQ_CONSTS_SVH
`define OTQ_CONSTS_SVH

`define OTQ_CLK_PERIOD_NS 40
`define OTQ_PULSE_STEP_NS 1000000
`define OTQ_CLKS_PER_MS (`OTQ_PULSE_STEP_NS / `OTQ_CLK_PERIOD_NS)

`define OTQ_ADDR_W 5
`define OTQ_OFF_CTRL 5'h00
`define OTQ_OFF_TREND 5'h04
`define OTQ_OFF_QUAL 5'h08
`define OTQ_OFF_PULSE 5'h0c
`define OTQ_OFF_STATUS 5'h10

`define OTQ_CTRL_SRC 2:0
`define OTQ_CTRL_TMODE 4:3
`define OTQ_CTRL_DPT_EN 5
`define OTQ_CTRL_INVERT 6
`define OTQ_CTRL_ROUTE 8:7
`define OTQ_TREND_PERIOD 7:0
`define OTQ_TREND_TARGET 15:8
`define OTQ_TREND_THR 31:16
`define OTQ_QUAL_EN 3:0
`define OTQ_QUAL_THR 11:4
`define OTQ_PULSE_W 15:0
`define OTQ_STAT_COUNT 7:0
`define OTQ_STAT_ACTIVE 8
`define OTQ_STAT_QHIT 9
`define OTQ_STAT_DCOUNT 31:16

`define OTQ_RST_CTRL 32'h0000_0008
`define OTQ_RST_TREND 32'h0000_0000
`define OTQ_RST_QUAL 32'h0000_0aa0
`define OTQ_RST_PULSE 32'h0000_01f4

`define OTQ_HIST_LEN 255

`endif

// ### rtl/otq_pkg.sv
// Types shared by the output 1 trend and quality trigger.
// Assumes otq_consts.svh for the numeric layout.
`include "otq_consts.svh"
package otq_pkg;

  typedef enum logic [1:0] {
    TREND_MISMATCH = 2'h0,
    TREND_NO_READ = 2'h1,
    TREND_DECODES = 2'h2
  } trend_mode_e;

  typedef enum logic [2:0] {
    SRC_MISS_OR_NOREAD = 3'h0,
    SRC_MATCH = 3'h1,
    SRC_MISMATCH = 3'h2,
    SRC_NO_READ = 3'h3,
    SRC_TREND = 3'h4,
    SRC_QUALITY = 3'h5,
    SRC_DIAG = 3'h6,
    SRC_IN_CYCLE = 3'h7
  } out_source_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ACK = 2'h1
  } bus_state_e;

  // One read cycle's result from the decode engine
  typedef struct packed {
    logic cycle_done;
    logic no_read;
    logic mismatch;
    logic [15:0] decode_count;
  } read_result_s;

  // Graded metrics: contrast, growth, axial, spare correction (bit pairs 0..3)
  typedef struct packed {
    logic valid;
    logic [3:0][1:0] grade;
  } grade_s;

  typedef struct packed {
    logic [`OTQ_HIST_LEN-1:0] hist;
  } window_s;

  typedef struct packed {
    bus_state_e bus;
    logic [31:0] rdata;
    logic [2:0] src;
    logic [1:0] tmode;
    logic dpt_en;
    logic invert;
    logic [1:0] route;
    logic [7:0] period;
    logic [7:0] target;
    logic [15:0] dpt_thr;
    logic [3:0] q_en;
    logic [7:0] q_thr;
    logic [15:0] pulse_w;
    logic eval_pend;
    logic qual_hit;
    logic [15:0] last_count;
    logic [7:0] win_count;
    logic [15:0] tick_cnt;
    logic [15:0] ms_left;
    logic out_pin;
    logic [2:0] route_pulse;
  } core_s;

endpackage : otq_pkg

// ### rtl/trend_window.sv
// Sliding history of trend events, newest in bit 0.
// Assumes push and clear come from logic on the same clock.
`timescale 1ns/100ps
`include "otq_consts.svh"
module trend_window (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Event history control
  input wire logic push_i,
  input wire logic event_i,
  input wire logic clear_i,
  input wire logic [7:0] period_i,
  // Events inside the window
  output logic [7:0] count_o
);
  import otq_pkg::*;

  window_s s;
  window_s next_s;
  logic [`OTQ_HIST_LEN-1:0] masked;

  for (genvar i = 0; i < `OTQ_HIST_LEN; i++) begin : g_mask
    assign masked[i] = s.hist[i] & (8'(i) < period_i);
  end

  always_comb begin
    count_o = 8'h00;
    for (int i = 0; i < `OTQ_HIST_LEN; i++) begin
      count_o = count_o + 8'(masked[i]);
    end
  end

  always_comb begin
    next_s = s;
    if (clear_i) begin
      next_s.hist = '0;
    end else if (push_i) begin
      next_s.hist = {s.hist[`OTQ_HIST_LEN-2:0], event_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : trend_window

// ### rtl/output_trend_quality_trigger.sv
// Output 1 decision logic: trend analysis, symbol quality, pulse shaping.
// Assumes decode-engine inputs are synchronous to sys_clk_i; registers over Avalon-MM.
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "otq_consts.svh"
// Operation
// - Trend mode: mismatch, no-read, decodes; default no-read
// - Mismatch count reaching target activates output
// - No-read count reaching target activates output
// - Decode-event count reaching target activates output
// - Evaluation period 0..255 triggers, default 0
// - Event target 0..255, default 0
// - Cycle decode count below threshold is event
// - Decodes mode needs status enable; appends count
// - Trend drives output only when source trend
// - Trend result routable to one of three outputs
// - Quality drives output only when source quality
// - Four metric enables, default disabled
// - Two-bit grade thresholds, default grade C
// - Source codes four trend, five quality
// - Active for pulse width in 1 ms steps
module output_trend_quality_trigger #(
  parameter int unsigned CLKS_PER_MS = `OTQ_CLKS_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Avalon-MM slave
  input wire logic [`OTQ_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Decode engine results
  input wire otq_pkg::read_result_s read_result_i,
  input wire otq_pkg::grade_s grade_i,
  input wire logic diag_warn_i,
  input wire logic in_read_cycle_i,
  // Discrete output and side effects
  output logic out1_o,
  output logic append_count_o,
  output logic [2:0] trend_route_o
);
  import otq_pkg::*;

  logic [1:0] rst_sync;
  logic rst_n;
  core_s s;
  core_s next_s;
  logic [7:0] window_count;
  logic push;
  logic trend_event;
  logic trend_fire;
  logic window_clear;
  logic [3:0] metric_met;
  logic qual_fire;
  logic activate;
  logic bus_req;
  logic bus_write;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic cfg_trend_write;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic [31:0] reg_word(input core_s c, input logic [`OTQ_ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case ({a[`OTQ_ADDR_W-1:2], 2'h0})
      `OTQ_OFF_CTRL: begin
        w[`OTQ_CTRL_SRC] = c.src;
        w[`OTQ_CTRL_TMODE] = c.tmode;
        w[`OTQ_CTRL_DPT_EN] = c.dpt_en;
        w[`OTQ_CTRL_INVERT] = c.invert;
        w[`OTQ_CTRL_ROUTE] = c.route;
      end
      `OTQ_OFF_TREND: begin
        w[`OTQ_TREND_PERIOD] = c.period;
        w[`OTQ_TREND_TARGET] = c.target;
        w[`OTQ_TREND_THR] = c.dpt_thr;
      end
      `OTQ_OFF_QUAL: begin
        w[`OTQ_QUAL_EN] = c.q_en;
        w[`OTQ_QUAL_THR] = c.q_thr;
      end
      `OTQ_OFF_PULSE: begin
        w[`OTQ_PULSE_W] = c.pulse_w;
      end
      `OTQ_OFF_STATUS: begin
        w[`OTQ_STAT_COUNT] = c.win_count;
        w[`OTQ_STAT_ACTIVE] = (c.ms_left != 16'h0000);
        w[`OTQ_STAT_QHIT] = c.qual_hit;
        w[`OTQ_STAT_DCOUNT] = c.last_count;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction : reg_word

  trend_window u_window (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_n),
    .push_i(push),
    .event_i(trend_event),
    .clear_i(window_clear),
    .period_i(s.period),
    .count_o(window_count)
  );

  assign bus_req = avs_read_i | avs_write_i;
  // Access completes in the one cycle waitrequest is low
  assign bus_write = avs_write_i && (s.bus == BUS_ACK);
  assign cur_word = reg_word(s, avs_address_i);
  assign wr_word = merge_bytes(cur_word, avs_writedata_i, avs_byteenable_i);
  assign rd_word = cur_word;
  // Changing trend setup restarts the window so old events never mix in
  assign cfg_trend_write = bus_write &&
    (({avs_address_i[`OTQ_ADDR_W-1:2], 2'h0} == `OTQ_OFF_CTRL) ||
     ({avs_address_i[`OTQ_ADDR_W-1:2], 2'h0} == `OTQ_OFF_TREND));

  assign push = read_result_i.cycle_done;

  always_comb begin
    trend_event = 1'b0;
    case (trend_mode_e'(s.tmode))
      TREND_MISMATCH: begin
        trend_event = read_result_i.mismatch;
      end
      TREND_NO_READ: begin
        trend_event = read_result_i.no_read;
      end
      // Low decode count, gated by enable
      TREND_DECODES: begin
        trend_event = s.dpt_en && (read_result_i.decode_count < s.dpt_thr);
      end
      default: begin
        trend_event = 1'b0;
      end
    endcase
  end

  // Fire when window count reaches target
  assign trend_fire = s.eval_pend && (s.target != 8'h00) && (window_count >= s.target);
  assign window_clear = trend_fire | cfg_trend_write;

  // Enabled metric at or past its grade
  for (genvar m = 0; m < 4; m++) begin : g_metric
    assign metric_met[m] = s.q_en[m] && (grade_i.grade[m] >= s.q_thr[m*2 +: 2]);
  end
  assign qual_fire = grade_i.valid && (|metric_met);

  always_comb begin
    activate = 1'b0;
    case (out_source_e'(s.src))
      SRC_MISS_OR_NOREAD: begin
        activate = push && (read_result_i.no_read || read_result_i.mismatch);
      end
      SRC_MATCH: begin
        activate = push && !read_result_i.no_read && !read_result_i.mismatch;
      end
      SRC_MISMATCH: begin
        activate = push && read_result_i.mismatch;
      end
      SRC_NO_READ: begin
        activate = push && read_result_i.no_read;
      end
      SRC_TREND: begin
        activate = trend_fire && (s.route == 2'h0);
      end
      SRC_QUALITY: begin
        activate = qual_fire;
      end
      SRC_DIAG: begin
        activate = diag_warn_i;
      end
      SRC_IN_CYCLE: begin
        activate = in_read_cycle_i;
      end
      default: begin
        activate = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.route_pulse = 3'h0;
    // Bus: one wait cycle, then a single acknowledged cycle
    case (s.bus)
      BUS_IDLE: begin
        if (bus_req) begin
          next_s.bus = BUS_ACK;
          next_s.rdata = avs_read_i ? rd_word : 32'h0000_0000;
        end
      end
      BUS_ACK: begin
        next_s.bus = BUS_IDLE;
      end
      default: begin
        next_s.bus = BUS_IDLE;
      end
    endcase
    if (bus_write) begin
      case ({avs_address_i[`OTQ_ADDR_W-1:2], 2'h0})
        `OTQ_OFF_CTRL: begin
          next_s.src = wr_word[`OTQ_CTRL_SRC];
          next_s.tmode = wr_word[`OTQ_CTRL_TMODE];
          next_s.dpt_en = wr_word[`OTQ_CTRL_DPT_EN];
          next_s.invert = wr_word[`OTQ_CTRL_INVERT];
          next_s.route = wr_word[`OTQ_CTRL_ROUTE];
        end
        `OTQ_OFF_TREND: begin
          next_s.period = wr_word[`OTQ_TREND_PERIOD];
          next_s.target = wr_word[`OTQ_TREND_TARGET];
          next_s.dpt_thr = wr_word[`OTQ_TREND_THR];
        end
        `OTQ_OFF_QUAL: begin
          next_s.q_en = wr_word[`OTQ_QUAL_EN];
          next_s.q_thr = wr_word[`OTQ_QUAL_THR];
        end
        `OTQ_OFF_PULSE: begin
          next_s.pulse_w = wr_word[`OTQ_PULSE_W];
        end
        default: begin
          next_s.pulse_w = s.pulse_w;
        end
      endcase
    end
    // Window count is sampled one cycle after each push
    next_s.eval_pend = push && !cfg_trend_write;
    next_s.win_count = window_clear ? 8'h00 : window_count;
    if (push) begin
      next_s.last_count = read_result_i.decode_count;
    end
    if (grade_i.valid) begin
      next_s.qual_hit = |metric_met;
    end
    // Trend result to the selected output
    if (trend_fire && (s.route != 2'h3)) begin
      next_s.route_pulse = 3'(3'h1 << s.route);
    end
    // Hold active for the pulse width in ms
    if (activate && (s.pulse_w != 16'h0000)) begin
      next_s.ms_left = s.pulse_w;
      next_s.tick_cnt = 16'h0000;
    end else if (s.ms_left != 16'h0000) begin
      if (s.tick_cnt == 16'(CLKS_PER_MS - 1)) begin
        next_s.tick_cnt = 16'h0000;
        next_s.ms_left = s.ms_left - 16'h0001;
      end else begin
        next_s.tick_cnt = s.tick_cnt + 16'h0001;
      end
    end
    next_s.out_pin = (next_s.ms_left != 16'h0000) ^ next_s.invert;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.src <= 3'(`OTQ_RST_CTRL);
      s.tmode <= 2'(`OTQ_RST_CTRL >> 3);
      s.q_thr <= 8'(`OTQ_RST_QUAL >> 4);
      s.pulse_w <= 16'(`OTQ_RST_PULSE);
      s.bus <= BUS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = (s.bus != BUS_ACK);
  assign out1_o = s.out_pin;
  // Append count while decodes status enabled
  assign append_count_o = s.dpt_en;
  assign trend_route_o = s.route_pulse;

endmodule : output_trend_quality_trigger

// ### bench/otq_properties.sv
// Checker for the output 1 trigger: bus handshake, reset values, pulse shaping.
// Assumes it is bound into output_trend_quality_trigger; pulse checks skip an inverted line.
`timescale 1ns/100ps
`include "otq_consts.svh"
module otq_properties #(
  parameter int unsigned CLKS_PER_MS = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register bus
  input wire logic [`OTQ_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Outputs
  input wire logic out1_o,
  input wire logic append_count_o,
  input wire logic [2:0] trend_route_o
);
  logic [15:0] pw;
  logic dpt;
  logic dpt_d;
  logic inv;
  logic [31:0] run;
  logic wr_ok;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  assign wr_ok = avs_write_i && !avs_waitrequest_o && (avs_byteenable_i[1:0] == 2'h3);
  // Shadow of width and control, to size pulses
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pw <= 16'(`OTQ_RST_PULSE);
      dpt <= 1'b0;
      dpt_d <= 1'b0;
      inv <= 1'b0;
      run <= 32'h0;
    end else begin
      dpt_d <= dpt;
      run <= out1_o ? run + 32'h1 : 32'h0;
      if (wr_ok && avs_address_i[4:2] == 3'h0) begin
        dpt <= avs_writedata_i[5];
        inv <= avs_writedata_i[6];
      end
      if (wr_ok && avs_address_i[4:2] == 3'h3) begin
        pw <= avs_writedata_i[15:0];
      end
    end
  end
  AST_ACK_NEXT:
    assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");
  AST_ACK_ONE:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_CAUSE:
    assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without a request");
  AST_RDATA_HOLD:
    assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o)
    else $error("read data changed outside an answer");
  AST_RST_VALS:
    assert property ($rose(rst_b_i) |-> avs_waitrequest_o && !out1_o && trend_route_o == 3'h0)
    else $error("outputs not at reset values");
  AST_ROUTE_ONEHOT:
    assert property ($onehot0(trend_route_o))
    else $error("trend result sent to more than one output");
  AST_APPEND:
    assert property (dpt == dpt_d |-> append_count_o == dpt)
    else $error("count append does not follow its enable");
  AST_PULSE_LEN:
    assert property ($fell(out1_o) && !inv |-> run >= pw * CLKS_PER_MS)
    else $error("output pulse shorter than its width");
  AST_PULSE_ZERO:
    assert property ($rose(out1_o) && !inv |-> pw != 16'h0)
    else $error("output activated with zero width");
endmodule : otq_properties

bind output_trend_quality_trigger otq_properties #(.CLKS_PER_MS(CLKS_PER_MS)) u_props (
  .sys_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .out1_o, .append_count_o,
  .trend_route_o
);

// ### bench/plc_relay_model.sv
// Model of the relay input watching output 1.
// Assumes the line is sampled on the system clock, active high.
`timescale 1ns/100ps
module plc_relay_model (
  // Clock
  input wire logic sys_clk_i,
  // Discrete line
  input wire logic line_i,
  // Observations
  output int n_act_o,
  output int last_len_o
);
  logic prev = 1'b0;
  int run = 0;
  // Each activation edge counted, length kept
  always @(posedge sys_clk_i) begin
    prev <= line_i;
    if (line_i === 1'b1 && prev !== 1'b1) n_act_o <= n_act_o + 1;
    if (line_i === 1'b1) run <= run + 1;
    else begin
      if (prev === 1'b1) last_len_o <= run;
      run <= 0;
    end
  end
endmodule : plc_relay_model

// ### bench/output_trend_quality_trigger_tb_top.sv
// Testbench top for the output 1 trend and quality trigger.
// Assumes a 4-cycle millisecond; bus answers are polled, never counted.
`timescale 1ns/100ps
`include "otq_consts.svh"
module output_trend_quality_trigger_tb_top;
  import otq_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] adr = 5'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq;
  read_result_s rr = '0;
  grade_s gr = '0;
  logic diag = 1'b0;
  logic inrc = 1'b0;
  logic out1;
  logic app;
  logic [2:0] route;
  int n_act;
  int last_len;
  int rt [3];
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] q;

  always #20 sys_clk_i = ~sys_clk_i;

  output_trend_quality_trigger #(.CLKS_PER_MS(4)) DUT (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .read_result_i(rr), .grade_i(gr), .diag_warn_i(diag),
    .in_read_cycle_i(inrc), .out1_o(out1), .append_count_o(app), .trend_route_o(route)
  );
  plc_relay_model plc (.sys_clk_i(sys_clk_i), .line_i(out1), .n_act_o(n_act),
    .last_len_o(last_len));

  always @(posedge sys_clk_i) begin
    for (int r = 0; r < 3; r++) if (route[r] === 1'b1) rt[r]++;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (wreq !== 1'b0 && i < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge sys_clk_i);
    if (i >= 20) begin
      n_fail++;
      $display("Error at %0t: bus timeout", $time);
      wrap_up();
    end
  endtask : bus

  // One read cycle, trend event or not for mode m
  task automatic send(input int m, input bit e);
    rr <= '{1'b1, (m == 1) && e, (m == 0) && e, (m == 2 && e) ? 16'h4 : 16'h5};
    @(posedge sys_clk_i);
    rr <= '0;
    repeat (4) @(posedge sys_clk_i);
  endtask : send

  task automatic grade(input logic [7:0] v);
    gr <= {1'b1, v};
    @(posedge sys_clk_i);
    gr <= '0;
    repeat (8) @(posedge sys_clk_i);
  endtask : grade

  task automatic t_regs;
    bus(1'b0, `OTQ_OFF_CTRL, 32'h0);
    chk(q, 32'h8);
    bus(1'b0, `OTQ_OFF_TREND, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `OTQ_OFF_QUAL, 32'h0);
    chk(q, 32'haa0);
    bus(1'b0, `OTQ_OFF_PULSE, 32'h0);
    chk(q, 32'd500);
    chk(app, 32'h0);
    bus(1'b1, `OTQ_OFF_STATUS, 32'hffffffff);
    bus(1'b0, `OTQ_OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'h14, 32'hffffffff);
    bus(1'b0, 5'h14, 32'h0);
    chk(q, 32'h0);
    be <= 4'h2;
    bus(1'b1, `OTQ_OFF_TREND, 32'hffffffff);
    be <= 4'hf;
    bus(1'b0, `OTQ_OFF_TREND, 32'h0);
    chk(q, 32'h0000ff00);
    bus(1'b1, `OTQ_OFF_TREND, 32'h0);
  endtask : t_regs

  task automatic t_trend;
    int a;
    bus(1'b1, `OTQ_OFF_PULSE, 32'h1);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, `OTQ_OFF_CTRL, 32'h24 | (m << 3));
      bus(1'b1, `OTQ_OFF_TREND, 32'h0005_0204);
      chk(app, 32'h1);
      a = n_act;
      send(m, 1'b1);
      send(m, 1'b0);
      send(m, 1'b0);
      chk(n_act, a);
      send(m, 1'b1);
      chk(n_act, a + 1);
      send(m, 1'b1);
      repeat (3) send(m, 1'b0);
      send(m, 1'b1);
      chk(n_act, a + 1);
      chk(last_len >= 4 && last_len <= 5, 32'h1);
    end
    bus(1'b1, `OTQ_OFF_CTRL, 32'h14);
    bus(1'b1, `OTQ_OFF_TREND, 32'h0005_0104);
    send(2, 1'b1);
    send(2, 1'b1);
    chk(n_act, a + 1);
    chk(app, 32'h0);
  endtask : t_trend

  task automatic t_route;
    int a;
    int b;
    int s;
    bus(1'b1, `OTQ_OFF_TREND, 32'h0005_0104);
    for (int r = 1; r < 4; r++) begin
      bus(1'b1, `OTQ_OFF_CTRL, 32'he | (r << 7));
      a = n_act;
      b = rt[r % 3];
      s = rt[0] + rt[1] + rt[2];
      send(1, 1'b1);
      chk(n_act, a);
      chk(rt[r % 3], b + (r < 3));
      chk(rt[0] + rt[1] + rt[2], s + (r < 3));
    end
  endtask : t_route

  task automatic t_other;
    int a;
    a = n_act;
    bus(1'b1, `OTQ_OFF_CTRL, 32'h6);
    diag <= 1'b1;
    @(posedge sys_clk_i);
    diag <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk(n_act, a + 1);
    bus(1'b1, `OTQ_OFF_CTRL, 32'h7);
    for (int k = 0; k < 2; k++) begin
      inrc <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      inrc <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      chk(n_act, a + 2);
      bus(1'b1, `OTQ_OFF_PULSE, 32'h0);
    end
    bus(1'b1, `OTQ_OFF_PULSE, 32'h1);
  endtask : t_other

  task automatic t_quality;
    logic [7:0] v;
    int a;
    bus(1'b1, `OTQ_OFF_CTRL, 32'h1d);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `OTQ_OFF_QUAL, 32'haa0 | (32'h1 << m));
      a = n_act;
      v = 8'hff;
      v[2 * m +: 2] = 2'h1;
      grade(v);
      chk(n_act, a);
      v[2 * m +: 2] = 2'h2;
      grade(v);
      chk(n_act, a + 1);
    end
    bus(1'b1, `OTQ_OFF_CTRL, 32'h1c);
    grade(8'hff);
    chk(n_act, a + 1);
  endtask : t_quality

  // Plain read-result sources, status word, inverted line
  task automatic t_src;
    int a;
    bus(1'b1, `OTQ_OFF_TREND, 32'h0000_0004);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, `OTQ_OFF_CTRL, 32'h8 | c);
      a = n_act;
      send(0, 1'b1);
      send(1, 1'b1);
      send(3, 1'b0);
      chk(n_act, a + ((c == 0) ? 2 : 1));
    end
    bus(1'b0, `OTQ_OFF_STATUS, 32'h0);
    chk(q, 32'h0005_0201);
    bus(1'b1, `OTQ_OFF_CTRL, 32'h4b);
    @(posedge sys_clk_i);
    chk(out1, 32'h1);
    a = n_act;
    send(1, 1'b1);
    repeat (2) @(posedge sys_clk_i);
    chk(n_act, a + 1);
    chk(out1, 32'h1);
    bus(1'b1, `OTQ_OFF_CTRL, 32'h8);
    chk(out1, 32'h0);
  endtask : t_src

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_regs();
    t_trend();
    t_route();
    t_other();
    t_quality();
    t_src();
    wrap_up();
  end
endmodule : output_trend_quality_trigger_tb_top
